// >>> src/pwdg_pkg.sv
package pwdg_pkg;

	// Counting chain widths
	localparam int PWDG_TIMER_W = 14;
	localparam int PWDG_PRESC_W = 7;
	localparam int PWDG_PS_W    = 3;

	// Special function register addresses
	localparam logic [7:0] PWDG_RESTART_ADDR = 8'hA6;
	localparam logic [7:0] PWDG_CONTROL_ADDR = 8'hA7;

	// Key sequence bytes
	localparam logic [7:0] PWDG_KEY_FIRST  = 8'h1E;
	localparam logic [7:0] PWDG_KEY_SECOND = 8'hE1;

	// Control register field positions
	localparam int PWDG_PS_LSB   = 5;
	localparam int PWDG_IDLE_BIT = 4;
	localparam int PWDG_OVF_BIT  = 1;
	localparam int PWDG_RUN_BIT  = 0;

	// Reset values
	localparam logic [PWDG_PS_W-1:0] PWDG_PS_RST   = 3'h0;
	localparam logic                 PWDG_IDLE_RST = 1'h0;
	localparam logic                 PWDG_OVF_RST  = 1'h0;
	localparam logic                 PWDG_RUN_RST  = 1'h0;
	localparam logic [7:0]           PWDG_RDATA_RST = 8'h00;

	typedef enum logic {
		PWDG_KEY_WAIT_FIRST,
		PWDG_KEY_WAIT_SECOND
	} pwdg_key_state_type;

endpackage

// >>> src/pwdg_if.sv
`timescale 1ns/1ps

interface pwdg_cnt_if;
	logic       run;
	logic       freeze;
	logic       clear;
	logic [2:0] period_sel;
	logic       expire;

	modport ctrl (output run, output freeze, output clear, output period_sel, input expire);
	modport cnt  (input run, input freeze, input clear, input period_sel, output expire);
endinterface

interface pwdg_key_if;
	logic       key_wr;
	logic       other_wr;
	logic [7:0] key_data;
	logic       good;
	logic       bad;

	modport ctrl (output key_wr, output other_wr, output key_data, input good, input bad);
	modport chk  (input key_wr, input other_wr, input key_data, output good, output bad);
endinterface

// >>> src/pwdg_counter.sv
`timescale 1ns/1ps

module pwdg_counter
	import pwdg_pkg::*;
#(
	parameter int TIMER_W = PWDG_TIMER_W,
	parameter int PRESC_W = PWDG_PRESC_W
) (
	input  wire logic   clk_i,
	input  wire logic   reset_i,
	pwdg_cnt_if.cnt     cnt
);

	typedef struct packed {
		logic [PRESC_W-1:0] presc;
		logic [TIMER_W-1:0] timer;
	} pwdg_cnt_state_type;

	pwdg_cnt_state_type state;
	pwdg_cnt_state_type next_state;
	logic [PRESC_W-1:0] presc_mask;
	logic               tick;
	logic               advance;

	// Prescaler divides by 2^sel, so the period is 2^(TIMER_W+sel) cycles
	always_comb begin
		presc_mask = PRESC_W'((1 << cnt.period_sel) - 1);
		tick       = (state.presc & presc_mask) == presc_mask;
		advance    = cnt.run && !cnt.freeze;
	end

	assign cnt.expire = advance && tick && (&state.timer);

	always_comb begin
		next_state = state;
		if (reset_i || cnt.clear || !cnt.run) begin
			next_state = '0;
		end else if (advance) begin
			next_state.presc = state.presc + PRESC_W'(1);
			if (tick) begin
				next_state.timer = state.timer + TIMER_W'(1);
			end
		end
	end

	always_ff @(posedge clk_i) begin
		state <= next_state;
	end

endmodule

// >>> src/pwdg_key_check.sv
`timescale 1ns/1ps

module pwdg_key_check
	import pwdg_pkg::*;
(
	input  wire logic   clk_i,
	input  wire logic   reset_i,
	pwdg_key_if.chk     key
);

	typedef struct packed {
		pwdg_key_state_type phase;
	} pwdg_chk_state_type;

	pwdg_chk_state_type state;
	pwdg_chk_state_type next_state;

	always_comb begin
		key.good = 1'b0;
		key.bad  = 1'b0;
		unique case (state.phase)
			PWDG_KEY_WAIT_FIRST: begin
				key.bad = key.key_wr && (key.key_data != PWDG_KEY_FIRST);
			end
			PWDG_KEY_WAIT_SECOND: begin
				key.good = key.key_wr && (key.key_data == PWDG_KEY_SECOND);
				// A foreign write between the two keys breaks the sequence
				key.bad  = (key.key_wr && (key.key_data != PWDG_KEY_SECOND))
					|| key.other_wr;
			end
		endcase
	end

	always_comb begin
		next_state = state;
		if (reset_i) begin
			next_state.phase = PWDG_KEY_WAIT_FIRST;
		end else begin
			unique case (state.phase)
				PWDG_KEY_WAIT_FIRST: begin
					if (key.key_wr && key.key_data == PWDG_KEY_FIRST) begin
						next_state.phase = PWDG_KEY_WAIT_SECOND;
					end
				end
				PWDG_KEY_WAIT_SECOND: begin
					if (key.key_wr || key.other_wr) begin
						next_state.phase = PWDG_KEY_WAIT_FIRST;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		state <= next_state;
	end

endmodule

// >>> src/pwdg_top.sv
// Operation
// - The guard timer counts clock cycles with a period of 16K to 2048K cycles chosen by a 3-bit field.
// - Any reset disables the guard timer and it does not count in power-down mode.
// - Expiry of an enabled, unfed guard timer emits an internal reset pulse.
// - The counting chain is a 14-bit timer behind a 7-bit prescaler.
// - Writing 1EH then E1H to the restart key register starts the timer.
// - The read-only running flag shows whether the timer runs.
// - Repeating the same key pair before expiry feeds the timer and avoids the reset.
// - A wrong enable or feed sequence issues an immediate guard reset.
// - With idle freeze at 0 the timer counts in idle; at 1 it holds while idle.
// - The overflow flag sets on timeout and on a wrong sequence; only a software write of 0 or a power-on reset clears it.
// - The restart key register is write-only at A6H and stores nothing readable.
`timescale 1ns/1ps

module pwdg_top
	import pwdg_pkg::*;
#(
	parameter int TIMER_W = PWDG_TIMER_W,
	parameter int PRESC_W = PWDG_PRESC_W
) (
	input  wire logic       clk_i,
	input  wire logic       reset_i,
	input  wire logic       por_i,
	input  wire logic [7:0] sfr_addr_i,
	input  wire logic       sfr_wr_i,
	input  wire logic [7:0] sfr_wdata_i,
	input  wire logic       sfr_rd_i,
	input  wire logic       idle_i,
	input  wire logic       power_down_i,
	output logic      [7:0] sfr_rdata_o,
	output logic            guard_reset_o,
	output logic            running_flag_o,
	output logic            overflow_reset_flag_o
);

	typedef struct packed {
		logic [PWDG_PS_W-1:0] period_sel;
		logic                 idle_freeze;
		logic                 overflow;
		logic                 running;
		logic                 reset_pulse;
		logic [7:0]           rdata;
	} pwdg_top_state_type;

	pwdg_top_state_type state;
	pwdg_top_state_type next_state;
	logic [7:0]         control_view;
	logic               ctrl_wr;
	logic               trip;

	pwdg_cnt_if cnt_bus ();
	pwdg_key_if key_bus ();

	pwdg_counter #(
		.TIMER_W (TIMER_W),
		.PRESC_W (PRESC_W)
	) counter_inst (
		.clk_i   (clk_i),
		.reset_i (reset_i),
		.cnt     (cnt_bus)
	);

	pwdg_key_check key_check_inst (
		.clk_i   (clk_i),
		.reset_i (reset_i),
		.key     (key_bus)
	);

	// Restart key writes only reach the checker, nothing is stored
	assign key_bus.key_wr   = sfr_wr_i && (sfr_addr_i == PWDG_RESTART_ADDR);
	assign key_bus.other_wr = sfr_wr_i && (sfr_addr_i != PWDG_RESTART_ADDR);
	assign key_bus.key_data = sfr_wdata_i;

	assign cnt_bus.run        = state.running;
	assign cnt_bus.clear      = key_bus.good;
	assign cnt_bus.period_sel = state.period_sel;
	// Power-down always stops counting, idle only when asked to
	assign cnt_bus.freeze     = power_down_i || (idle_i && state.idle_freeze);

	assign ctrl_wr = sfr_wr_i && (sfr_addr_i == PWDG_CONTROL_ADDR);
	assign trip    = cnt_bus.expire || key_bus.bad;

	always_comb begin
		control_view = 8'h00;
		control_view[PWDG_PS_LSB +: PWDG_PS_W] = state.period_sel;
		control_view[PWDG_IDLE_BIT]            = state.idle_freeze;
		control_view[PWDG_OVF_BIT]             = state.overflow;
		control_view[PWDG_RUN_BIT]             = state.running;
	end

	always_comb begin
		next_state = state;
		next_state.reset_pulse = trip;
		next_state.rdata = (sfr_rd_i && sfr_addr_i == PWDG_CONTROL_ADDR)
			? control_view : PWDG_RDATA_RST;
		if (ctrl_wr) begin
			next_state.period_sel  = sfr_wdata_i[PWDG_PS_LSB +: PWDG_PS_W];
			next_state.idle_freeze = sfr_wdata_i[PWDG_IDLE_BIT];
			// Writing zero clears the flag, writing one leaves it
			if (!sfr_wdata_i[PWDG_OVF_BIT]) begin
				next_state.overflow = 1'b0;
			end
		end
		if (key_bus.good) begin
			next_state.running = 1'b1;
		end
		// A trip beats a same-cycle clear of the flag
		if (trip) begin
			next_state.overflow = 1'b1;
			next_state.running  = 1'b0;
		end
		// Overflow survives a normal reset so software can see the cause
		if (por_i) begin
			next_state.overflow = PWDG_OVF_RST;
		end
		if (reset_i || por_i) begin
			next_state.period_sel  = PWDG_PS_RST;
			next_state.idle_freeze = PWDG_IDLE_RST;
			next_state.running     = PWDG_RUN_RST;
			next_state.reset_pulse = 1'b0;
			next_state.rdata       = PWDG_RDATA_RST;
		end
	end

	always_ff @(posedge clk_i) begin
		state <= next_state;
	end

	assign sfr_rdata_o           = state.rdata;
	assign guard_reset_o         = state.reset_pulse;
	assign running_flag_o        = state.running;
	assign overflow_reset_flag_o = state.overflow;

endmodule

// >>> sim/pwdg_checker.sv
`timescale 1ns/1ps
module pwdg_checker
	import pwdg_pkg::*;
(
	input wire logic       clk_i,
	input wire logic       reset_i,
	input wire logic       por_i,
	input wire logic [7:0] sfr_addr_i,
	input wire logic       sfr_wr_i,
	input wire logic [7:0] sfr_wdata_i,
	input wire logic       sfr_rd_i,
	input wire logic       idle_i,
	input wire logic       power_down_i,
	input wire logic [7:0] sfr_rdata_o,
	input wire logic       guard_reset_o,
	input wire logic       running_flag_o,
	input wire logic       overflow_reset_flag_o
);
	logic pend;
	wire  a6w = sfr_wr_i && sfr_addr_i == PWDG_RESTART_ADDR;
	wire  e1  = sfr_wdata_i == PWDG_KEY_SECOND;
	// First key byte seen, second still owed
	always_ff @(posedge clk_i) begin
		if (reset_i || por_i)
			pend <= 1'h0;
		else if (sfr_wr_i)
			pend <= !pend && a6w && sfr_wdata_i == PWDG_KEY_FIRST;
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i || por_i);
	property p_pulse; guard_reset_o && !sfr_wr_i |=> !guard_reset_o; endproperty
	a_pulse: assert property (p_pulse) else $error("reset pulse too long");
	property p_rst; disable iff (1'b0) reset_i |=> !running_flag_o && !guard_reset_o; endproperty
	a_rst: assert property (p_rst) else $error("reset left timer on");
	property p_bad;
		a6w && sfr_wdata_i != PWDG_KEY_FIRST && !e1 |=>
			guard_reset_o && overflow_reset_flag_o && !running_flag_o;
	endproperty
	a_bad: assert property (p_bad) else $error("bad key not tripped");
	property p_good; pend && a6w && e1 |=> running_flag_o && !guard_reset_o; endproperty
	a_good: assert property (p_good) else $error("good key not taken");
	property p_brk; pend && sfr_wr_i && !(a6w && e1) |=> guard_reset_o; endproperty
	a_brk: assert property (p_brk) else $error("broken pair not tripped");
	property p_ovf;
		overflow_reset_flag_o && !(sfr_wr_i && sfr_addr_i == PWDG_CONTROL_ADDR
			&& !sfr_wdata_i[PWDG_OVF_BIT]) |=> overflow_reset_flag_o;
	endproperty
	a_ovf: assert property (p_ovf) else $error("overflow flag lost");
	property p_rd;
		sfr_rd_i && sfr_addr_i == PWDG_CONTROL_ADDR |=> sfr_rdata_o[3:0] ==
			{2'h0, $past(overflow_reset_flag_o), $past(running_flag_o)};
	endproperty
	a_rd: assert property (p_rd) else $error("control read wrong");
	property p_rd6; sfr_rd_i && sfr_addr_i == PWDG_RESTART_ADDR |=> sfr_rdata_o == 8'h00; endproperty
	a_rd6: assert property (p_rd6) else $error("restart key readable");
	property p_frz; (power_down_i && !sfr_wr_i)[*3] |=> !guard_reset_o; endproperty
	a_frz: assert property (p_frz) else $error("tripped in power-down");
endmodule
bind pwdg_top pwdg_checker u_chk (.clk_i(clk_i), .reset_i(reset_i), .por_i(por_i),
	.sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i), .sfr_wdata_i(sfr_wdata_i),
	.sfr_rd_i(sfr_rd_i), .idle_i(idle_i), .power_down_i(power_down_i),
	.sfr_rdata_o(sfr_rdata_o), .guard_reset_o(guard_reset_o),
	.running_flag_o(running_flag_o), .overflow_reset_flag_o(overflow_reset_flag_o));

// >>> sim/tb_pwdg_top.sv
`timescale 1ns/1ps
module tb_pwdg_top;
	import pwdg_pkg::*;
	logic       clk_i = 1'h0, reset_i = 1'h1, por_i = 1'h1, sfr_wr_i = 1'h0, sfr_rd_i = 1'h0;
	logic       idle_i = 1'h0, power_down_i = 1'h0;
	logic [7:0] sfr_addr_i = 8'h00, sfr_wdata_i = 8'h00, sfr_rdata_o, rd_v;
	logic       guard_reset_o, running_flag_o, overflow_reset_flag_o;
	int         err_total = 0, checked = 0, n, trips = 0;
	always #2 clk_i = ~clk_i;
	always @(posedge clk_i) if (guard_reset_o === 1'h1) trips++;
	// Short timer: periods 16..2048 cycles
	pwdg_top #(.TIMER_W(4)) uut (.clk_i(clk_i), .reset_i(reset_i), .por_i(por_i),
		.sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i), .sfr_wdata_i(sfr_wdata_i),
		.sfr_rd_i(sfr_rd_i), .idle_i(idle_i), .power_down_i(power_down_i),
		.sfr_rdata_o(sfr_rdata_o), .guard_reset_o(guard_reset_o),
		.running_flag_o(running_flag_o), .overflow_reset_flag_o(overflow_reset_flag_o));
	task check(string nm, logic [31:0] got, logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			$display("ERROR %s expected %0h seen %0h", nm, exp, got);
			err_total++;
		end
	endtask
	task results();
		$display("checks %0d errors %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task rst(logic p);
		@(negedge clk_i);
		reset_i = 1'h1;
		por_i = p;
		repeat (8) @(negedge clk_i);
		reset_i = 1'h0;
		por_i = 1'h0;
	endtask
	task wr(logic [7:0] a, logic [7:0] d);
		@(negedge clk_i);
		sfr_addr_i = a;
		sfr_wdata_i = d;
		sfr_wr_i = 1'h1;
		@(negedge clk_i);
		sfr_wr_i = 1'h0;
	endtask
	task rd(logic [7:0] a);
		@(negedge clk_i);
		sfr_addr_i = a;
		sfr_rd_i = 1'h1;
		@(negedge clk_i);
		sfr_rd_i = 1'h0;
		rd_v = sfr_rdata_o;
	endtask
	task key();
		wr(PWDG_RESTART_ADDR, PWDG_KEY_FIRST);
		wr(PWDG_RESTART_ADDR, PWDG_KEY_SECOND);
	endtask
	// Bounded so a dead timer cannot hang the run
	task wait_trip();
		n = 0;
		while (guard_reset_o !== 1'h1 && n < 5000) begin
			@(negedge clk_i);
			n++;
		end
	endtask
	task t_timeout();
		for (int s = 0; s < 8; s++) begin
			rst(1'h0);
			if (s > 0) check("ovf kept", overflow_reset_flag_o, 1);
			check("run off", running_flag_o, 0);
			wr(PWDG_CONTROL_ADDR, 8'(s << 5));
			rd(PWDG_CONTROL_ADDR);
			check("ctrl", rd_v, s << 5);
			key();
			check("run", running_flag_o, 1);
			wait_trip();
			check("period", n >= (16 << s) - 1 && n <= (16 << s) + 2, 1);
			@(negedge clk_i);
			check("pulse", {guard_reset_o, overflow_reset_flag_o, running_flag_o}, 3'h2);
		end
	endtask
	task t_feed();
		rst(1'h1);
		key();
		trips = 0;
		repeat (6) begin
			repeat (8) @(negedge clk_i);
			wr(PWDG_RESTART_ADDR, PWDG_KEY_FIRST);
			rd(PWDG_RESTART_ADDR);
			check("wo", rd_v, 0);
			wr(PWDG_RESTART_ADDR, PWDG_KEY_SECOND);
		end
		check("fed", trips, 0);
	endtask
	task t_bad();
		logic [7:0] a2[3];
		logic [7:0] d2[3];
		a2 = '{8'hA6, 8'hA7, 8'hA6};
		d2 = '{8'h1E, 8'h00, 8'h55};
		wr(PWDG_RESTART_ADDR, 8'h55);
		wait_trip();
		check("bad first", n <= 1, 1);
		for (int i = 0; i < 3; i++) begin
			wr(PWDG_RESTART_ADDR, PWDG_KEY_FIRST);
			wr(a2[i], d2[i]);
			wait_trip();
			check("bad pair", n <= 1, 1);
		end
		// Ones in reserved and running bits must not stick
		wr(PWDG_CONTROL_ADDR, 8'hFD);
		rd(PWDG_CONTROL_ADDR);
		check("ovf clear", rd_v, 8'hF0);
	endtask
	task t_idle();
		rst(1'h1);
		wr(PWDG_CONTROL_ADDR, 8'h10);
		rd(PWDG_CONTROL_ADDR);
		check("idle bit", rd_v, 8'h10);
		key();
		trips = 0;
		idle_i = 1'h1;
		repeat (60) @(negedge clk_i);
		idle_i = 1'h0;
		power_down_i = 1'h1;
		repeat (60) @(negedge clk_i);
		power_down_i = 1'h0;
		check("frozen", trips, 0);
		wr(PWDG_CONTROL_ADDR, 8'h00);
		idle_i = 1'h1;
		wait_trip();
		check("idle count", n <= 18, 1);
		idle_i = 1'h0;
	endtask
	initial begin
		rst(1'h1);
		rd(PWDG_CONTROL_ADDR);
		check("ctrl rst", rd_v, 0);
		t_timeout();
		t_feed();
		t_bad();
		t_idle();
		results();
	end
	initial begin
		#300000;
		err_total++;
		results();
	end
endmodule
